// >>> logic/flash_pkg.sv
// shared constants and carrier types for the serial flash erase and power control block
//
// Function
// - a completed sector erase leaves every byte of the sector at all ones
// - sector erase accepted only while the write enable latch is set by write enable
// - any address in a sector selects it; address bits 23 down to 17 ignored
// - select must rise right after the last address bit, otherwise erase is dropped
// - select rise starts self-timed erase; progress flag is 1 during it, 0 after
// - write enable latch clears before the self-timed erase finishes
// - no erase of a sector that holds a hardware protected page
// - during any internal cycle, erase and power-down enter or release are rejected; release is not gated by other_cycle_busy here
// - select high with no internal cycle running gives ordinary standby
// - power-down entry is the bare opcode with select rising right after it
// - after a valid entry, wait a fixed delay, then enter lowest-power state
// - in lowest-power state every instruction except release is ignored
// - release rejected when extra serial clocks follow its opcode
// - after a valid release, wait the release delay, then return to standby
// - power-on always gives ordinary standby; power loss ends lowest-power state
// - while supply is below the inhibit threshold logic is held in reset
// - write enable and erase ignored until the power-up write delay has passed
// - power-on leaves the write enable latch cleared and the device in standby
package flash_pkg;

    // =========================================================
    // clock and timing
    localparam int unsigned core_clk_period_ns = 20;
    localparam int unsigned power_up_write_delay_us = 1000;
    localparam int unsigned sector_erase_time_us = 1000000;
    localparam int unsigned power_down_entry_delay_us = 3;
    localparam int unsigned release_delay_us = 30;
    localparam int unsigned supply_to_select_delay_us = 30;
    localparam int unsigned power_up_write_cycles = (power_up_write_delay_us * 1000) / core_clk_period_ns;
    localparam int unsigned sector_erase_cycles = (sector_erase_time_us * 1000) / core_clk_period_ns;
    localparam int unsigned power_down_entry_cycles =
        (power_down_entry_delay_us * 1000 + core_clk_period_ns - 1) / core_clk_period_ns;
    localparam int unsigned release_cycles = (release_delay_us * 1000 + core_clk_period_ns - 1) / core_clk_period_ns;

    // =========================================================
    // frame layout
    localparam int unsigned timer_width = 32;
    localparam int unsigned count_width = 16;
    localparam int unsigned shift_width = 32;
    localparam logic [15:0] opcode_bits = 16'h0008;
    localparam logic [15:0] erase_frame_bits = 16'h0020;
    localparam int unsigned opcode_msb = 31;
    localparam int unsigned opcode_lsb = 24;
    localparam int unsigned sector_bit = 16;
    localparam int unsigned sector_count = 2;

    // =========================================================
    // instruction codes
    localparam logic [7:0] write_enable_cmd = 8'h11;
    localparam logic [7:0] sector_erase_cmd = 8'h22;
    localparam logic [7:0] power_down_entry_cmd = 8'h33;
    localparam logic [7:0] power_down_release_cmd = 8'h44;

    // =========================================================
    // types
    typedef enum logic [2:0] {
        st_standby,
        st_erasing,
        st_entering,
        st_power_down,
        st_releasing
    } power_state_t;

    typedef struct packed {
        logic [15:0] bit_count;
        logic [31:0] shift;
    } frame_t;

    typedef struct packed {
        logic active;
        logic sector;
    } erase_req_t;

endpackage : flash_pkg

// >>> logic/bit_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    // destination clock
    input wire logic clk,
    // level from another domain
    input wire logic async_in,
    // synchronised level
    output logic sync_out
);

    logic meta_reg;

    // the first flop feeds only the second
    always_ff @(posedge clk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end

endmodule : bit_sync
`default_nettype wire

// >>> logic/serial_flash_erase_power_control.sv
// sector erase, deep power-down and power-on write inhibit control for a serial flash
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_power_control #(
    parameter int unsigned power_up_write_cycles = flash_pkg::power_up_write_cycles,
    parameter int unsigned sector_erase_cycles = flash_pkg::sector_erase_cycles
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // supply monitor: high while supply is above the write inhibit threshold
    input wire logic supply_ok,
    // serial link from the host
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    // hardware protection, one bit per sector, from pins
    input wire logic [1:0] sector_protected,
    // another program or write cycle of the device is running
    input wire logic other_cycle_busy,
    // status
    output logic write_in_progress_flag,
    output logic write_enable_latch,
    output logic standby_active,
    output logic low_power_active,
    output logic write_ready,
    // erase request to the array
    output flash_pkg::erase_req_t array_erase
);

    // =========================================================
    // link domain: shift in bits while selected
    logic spi_reset;
    flash_pkg::frame_t link_frame_reg;

    bit_sync spi_reset_sync (
        .clk(serial_clk),
        .async_in(reset | ~supply_ok),
        .sync_out(spi_reset)
    );

    // the counter is never cleared per frame: the serial clock stops between frames,
    // so the core side works out the frame length as a difference instead
    always_ff @(posedge serial_clk) begin
        if (spi_reset) begin
            link_frame_reg <= '0;
        end else if (!chip_select_n) begin
            link_frame_reg.shift <= {link_frame_reg.shift[30:0], serial_in};
            link_frame_reg.bit_count <= link_frame_reg.bit_count + 16'h0001;
        end
    end

    // =========================================================
    // core domain: synchronise pins
    logic supply_sync;
    logic select_n_sync;
    logic [1:0] protect_sync;
    logic core_reset;

    bit_sync supply_sync_inst (
        .clk(core_clk),
        .async_in(supply_ok),
        .sync_out(supply_sync)
    );

    bit_sync select_sync_inst (
        .clk(core_clk),
        .async_in(chip_select_n),
        .sync_out(select_n_sync)
    );

    bit_sync protect_sync_0 (
        .clk(core_clk),
        .async_in(sector_protected[0]),
        .sync_out(protect_sync[0])
    );

    bit_sync protect_sync_1 (
        .clk(core_clk),
        .async_in(sector_protected[1]),
        .sync_out(protect_sync[1])
    );

    // low supply holds every core register except the pin synchronisers in reset and ends power-down
    assign core_reset = reset | ~supply_sync;

    // =========================================================
    // frame end detection
    logic select_n_prev_reg;
    logic frame_end;
    logic [15:0] frame_start_count_reg;
    logic [15:0] frame_bits;
    logic [7:0] opcode;
    logic [7:0] short_opcode;
    logic erase_sector;

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            select_n_prev_reg <= 1'b1;
        end else begin
            select_n_prev_reg <= select_n_sync;
        end
    end

    assign frame_end = select_n_sync & ~select_n_prev_reg;

    // link registers are static here: the serial clock has stopped once select is high
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            frame_start_count_reg <= '0;
        end else if (frame_end) begin
            frame_start_count_reg <= link_frame_reg.bit_count;
        end
    end

    assign frame_bits = link_frame_reg.bit_count - frame_start_count_reg;
    assign opcode = link_frame_reg.shift[flash_pkg::opcode_msb:flash_pkg::opcode_lsb];
    assign short_opcode = link_frame_reg.shift[7:0];
    assign erase_sector = link_frame_reg.shift[flash_pkg::sector_bit];

    // =========================================================
    // core-side snapshot of the finished frame
    // the link word is taken once, at the synchronised select rise, and the
    // decode reads only these copies; this costs one core cycle of latency,
    // which a host waiting out the self-timed phases never notices
    logic decode_reg;
    logic [15:0] snap_bits_reg;
    logic [7:0] snap_opcode_reg;
    logic [7:0] snap_short_reg;
    logic snap_sector_reg;

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            decode_reg <= 1'b0;
        end else begin
            decode_reg <= frame_end;
        end
    end

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            snap_bits_reg <= '0;
            snap_opcode_reg <= '0;
            snap_short_reg <= '0;
            snap_sector_reg <= 1'b0;
        end else if (frame_end) begin
            snap_bits_reg <= frame_bits;
            snap_opcode_reg <= opcode;
            snap_short_reg <= short_opcode;
            snap_sector_reg <= erase_sector;
        end
    end

    // =========================================================
    // instruction decode at frame end
    logic is_write_enable;
    logic is_entry;
    logic is_release;
    logic is_erase;
    logic write_allowed;
    logic cycle_busy;

    assign cycle_busy = other_cycle_busy | write_in_progress_flag;
    assign write_allowed = write_ready & ~cycle_busy;
    assign is_write_enable = decode_reg && snap_bits_reg == flash_pkg::opcode_bits
        && snap_short_reg == flash_pkg::write_enable_cmd;
    // bare opcode only: any other frame length drops the instruction
    assign is_entry = decode_reg && snap_bits_reg == flash_pkg::opcode_bits
        && snap_short_reg == flash_pkg::power_down_entry_cmd;
    assign is_release = decode_reg && snap_bits_reg == flash_pkg::opcode_bits
        && snap_short_reg == flash_pkg::power_down_release_cmd;
    assign is_erase = decode_reg && snap_bits_reg == flash_pkg::erase_frame_bits
        && snap_opcode_reg == flash_pkg::sector_erase_cmd;

    // =========================================================
    // power-up write inhibit timer
    logic [31:0] power_up_count_reg;

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            power_up_count_reg <= '0;
        end else if (!write_ready) begin
            power_up_count_reg <= power_up_count_reg + 32'h0000_0001;
        end
    end

    // sticky until the next power-on reset: the array needs settling time after
    // supply has come up, and a later brown-out restarts the wait
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            write_ready <= 1'b0;
        end else if (power_up_count_reg + 32'h0000_0001 >= power_up_write_cycles) begin
            write_ready <= 1'b1;
        end
    end

    // =========================================================
    // power and erase state machine
    flash_pkg::power_state_t state_reg;
    flash_pkg::power_state_t state_next;
    logic [31:0] timer_reg;
    logic timer_done;
    logic erase_target_reg;

    assign timer_done = timer_reg == 32'h0000_0001;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            flash_pkg::st_standby: begin
                // other cycles running block erase and power-down entry
                if (!cycle_busy) begin
                    if (is_erase && write_enable_latch && write_ready
                        && !protect_sync[snap_sector_reg]) begin
                        state_next = flash_pkg::st_erasing;
                    end else if (is_entry) begin
                        state_next = flash_pkg::st_entering;
                    end
                end
            end
            flash_pkg::st_erasing: begin
                if (timer_done) begin
                    state_next = flash_pkg::st_standby;
                end
            end
            flash_pkg::st_entering: begin
                if (timer_done) begin
                    state_next = flash_pkg::st_power_down;
                end
            end
            flash_pkg::st_power_down: begin
                // only a clean release frame leaves this state
                if (is_release) begin
                    state_next = flash_pkg::st_releasing;
                end
            end
            flash_pkg::st_releasing: begin
                if (timer_done) begin
                    state_next = flash_pkg::st_standby;
                end
            end
            default: begin
                state_next = flash_pkg::st_standby;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            state_reg <= flash_pkg::st_standby;
        end else begin
            state_reg <= state_next;
        end
    end

    // one down-counter serves every self-timed phase
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            timer_reg <= '0;
        end else if (state_reg != state_next) begin
            case (state_next)
                flash_pkg::st_erasing: begin
                    timer_reg <= sector_erase_cycles;
                end
                flash_pkg::st_entering: begin
                    timer_reg <= flash_pkg::power_down_entry_cycles;
                end
                flash_pkg::st_releasing: begin
                    timer_reg <= flash_pkg::release_cycles;
                end
                default: begin
                    timer_reg <= '0;
                end
            endcase
        end else if (timer_reg != 32'h0000_0000) begin
            timer_reg <= timer_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            erase_target_reg <= 1'b0;
        end else if (state_reg == flash_pkg::st_standby && state_next == flash_pkg::st_erasing) begin
            erase_target_reg <= snap_sector_reg;
        end
    end

    // =========================================================
    // write enable latch
    // cleared as the erase starts, which is well before it finishes
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            write_enable_latch <= 1'b0;
        end else if (state_next == flash_pkg::st_erasing) begin
            write_enable_latch <= 1'b0;
        end else if (state_reg == flash_pkg::st_standby && is_write_enable && write_allowed) begin
            write_enable_latch <= 1'b1;
        end
    end

    // =========================================================
    // status outputs
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            write_in_progress_flag <= 1'b0;
        end else begin
            write_in_progress_flag <= state_next == flash_pkg::st_erasing;
        end
    end

    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            low_power_active <= 1'b0;
        end else begin
            low_power_active <= state_next == flash_pkg::st_power_down;
        end
    end

    // standby needs deselect and no cycle anywhere in the device
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            standby_active <= 1'b0;
        end else begin
            standby_active <= state_next == flash_pkg::st_standby && select_n_sync
                && !other_cycle_busy;
        end
    end

    // the array fills the whole sector with ones while this stands
    always_ff @(posedge core_clk) begin
        if (core_reset) begin
            array_erase <= '0;
        end else begin
            array_erase.active <= state_next == flash_pkg::st_erasing;
            array_erase.sector <= state_next == flash_pkg::st_erasing && state_reg == flash_pkg::st_standby
                ? snap_sector_reg : erase_target_reg;
        end
    end

endmodule : serial_flash_erase_power_control
`default_nettype wire

// >>> tb/serial_flash_erase_power_control_props.sv
// assertion checker for the sector erase and power control block
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_power_control_props #(
    parameter int unsigned sector_erase_cycles = 40
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_ok,
    // serial link and pins
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic [1:0] sector_protected,
    input wire logic other_cycle_busy,
    // status and array request
    input wire logic write_in_progress_flag,
    input wire logic write_enable_latch,
    input wire logic standby_active,
    input wire logic low_power_active,
    input wire logic write_ready,
    input wire flash_pkg::erase_req_t array_erase
);
    // =========================================================
    // erase length counter
    logic [31:0] erase_len_reg;
    always_ff @(posedge core_clk) begin
        if (reset || !write_in_progress_flag) begin
            erase_len_reg <= 32'h0000_0000;
        end else begin
            erase_len_reg <= erase_len_reg + 32'h0000_0001;
        end
    end

    // =========================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_flag_tracks_erase: assert property (array_erase.active == write_in_progress_flag)
        else $error("progress flag and erase request disagree");
    a_erase_needs_latch: assert property ($rose(array_erase.active) |-> $past(write_enable_latch))
        else $error("erase started without the write enable latch");
    a_latch_cleared: assert property ($rose(write_in_progress_flag) |-> !write_enable_latch)
        else $error("write enable latch still set during erase");
    a_erase_protect: assert property ($rose(array_erase.active) |-> !sector_protected[array_erase.sector])
        else $error("erase started on a protected sector");
    a_erase_length: assert property ($fell(write_in_progress_flag) |->
        ($past(erase_len_reg) + 32'h0000_0002 >= sector_erase_cycles) && ($past(erase_len_reg) <= sector_erase_cycles))
        else $error("erase cycle length wrong");
    a_power_excl: assert property (low_power_active |-> !standby_active && !write_in_progress_flag)
        else $error("lowest-power state overlaps standby or erase");
    a_ready_gate: assert property (!write_ready |-> !write_enable_latch)
        else $error("latch set before the power-up write delay");
    a_reset_state: assert property ($fell(reset) |-> !low_power_active && !write_enable_latch)
        else $error("state after reset not standby with latch clear");
    a_supply_reset: assert property (!supply_ok [*5] |-> !write_in_progress_flag && !low_power_active
        && !write_enable_latch)
        else $error("logic not held while supply is low");
endmodule : serial_flash_erase_power_control_props

bind serial_flash_erase_power_control serial_flash_erase_power_control_props #(
    .sector_erase_cycles(sector_erase_cycles)
) i_props (.core_clk(core_clk), .reset(reset), .supply_ok(supply_ok), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .sector_protected(sector_protected),
    .other_cycle_busy(other_cycle_busy), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch(write_enable_latch), .standby_active(standby_active),
    .low_power_active(low_power_active), .write_ready(write_ready), .array_erase(array_erase));
`default_nettype wire

// >>> tb/flash_host_model.sv
// behavioural serial host that drives select, link clock and data
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    // serial link to the device
    output var logic serial_clk,
    output var logic chip_select_n,
    output var logic serial_in
);
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end

    // =========================================================
    // one frame, msb first, link clock only runs inside it
    task automatic send(input logic [31:0] value, input int unsigned bits);
        // a 7 ns lag keeps link edges off the core clock edges
        #7;
        chip_select_n = 1'b0;
        #20;
        for (int i = int'(bits) - 1; i >= 0; i--) begin
            serial_in = value[i];
            #20 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
            #20;
        end
        chip_select_n = 1'b1;
        // released line must not keep looking valid
        serial_in = ~serial_in;
        #200;
    endtask : send

    // clocks with select high, so the link side can clear under reset
    task automatic idle_clocks(input int unsigned n);
        #7;
        repeat (n) begin
            serial_in = ~serial_in;
            #20 serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
            #20;
        end
    endtask : idle_clocks
endmodule : flash_host_model
`default_nettype wire

// >>> tb/serial_flash_erase_power_control_test.sv
// self-checking bench for the sector erase and power control block
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_power_control_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b0;
    logic [1:0] sector_protected = 2'h0;
    logic other_cycle_busy = 1'b0;
    wire logic serial_clk;
    wire logic chip_select_n;
    wire logic serial_in;
    logic write_in_progress_flag;
    logic write_enable_latch;
    logic standby_active;
    logic low_power_active;
    logic write_ready;
    flash_pkg::erase_req_t array_erase;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    always #10 core_clk = ~core_clk;

    flash_host_model i_host (.serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in));
    serial_flash_erase_power_control #(.power_up_write_cycles(2000), .sector_erase_cycles(40)) i_dut (
        .core_clk(core_clk), .reset(reset), .supply_ok(supply_ok), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .sector_protected(sector_protected),
        .other_cycle_busy(other_cycle_busy), .write_in_progress_flag(write_in_progress_flag),
        .write_enable_latch(write_enable_latch), .standby_active(standby_active),
        .low_power_active(low_power_active), .write_ready(write_ready), .array_erase(array_erase));

    // =========================================================
    // shared helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int unsigned n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // frame end needs about four core cycles to show
    task automatic frame(input logic [31:0] value, input int unsigned bits);
        i_host.send(value, bits);
        tick(8);
    endtask : frame

    task automatic wait_erase();
        for (int n = 0; n < 100 && write_in_progress_flag !== 1'b0; n++) tick(1);
    endtask : wait_erase

    // =========================================================
    // scenarios
    task automatic t_power_up();
        frame(32'h0000_0011, 8);
        check("latch_early", write_enable_latch, 1'b0);
        check("ready_early", write_ready, 1'b0);
        for (int n = 0; n < 3000 && write_ready !== 1'b1; n++) tick(1);
        check("ready", write_ready, 1'b1);
        check("latch_reset", write_enable_latch, 1'b0);
        check("standby_reset", standby_active, 1'b1);
        check("low_power_reset", low_power_active, 1'b0);
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_erase();
        frame(32'h0000_0011, 8);
        check("latch_set", write_enable_latch, 1'b1);
        frame(32'h22FF_0000, 32);
        check("wip_set", write_in_progress_flag, 1'b1);
        check("erase_sector", array_erase.sector, 1'b1);
        check("latch_cleared", write_enable_latch, 1'b0);
        check("standby_busy", standby_active, 1'b0);
        wait_erase();
        check("wip_clear", write_in_progress_flag, 1'b0);
        check("erase_done", array_erase.active, 1'b0);
        check("standby_after", standby_active, 1'b1);
        $display("test erase done");
    endtask : t_erase

    task automatic t_refused();
        frame(32'h2200_0000, 32);
        check("erase_no_latch", write_in_progress_flag, 1'b0);
        frame(32'h0000_0011, 8);
        frame(32'h0000_0022, 8);
        frame(32'h0022_0000, 24);
        check("erase_short", write_in_progress_flag, 1'b0);
        sector_protected <= 2'h1;
        frame(32'h0000_0011, 8);
        frame(32'h2200_1234, 32);
        check("erase_protected", write_in_progress_flag, 1'b0);
        sector_protected <= 2'h2;
        frame(32'h0000_0011, 8);
        frame(32'h2200_1234, 32);
        check("erase_open", array_erase.active, 1'b1);
        check("erase_sector0", array_erase.sector, 1'b0);
        wait_erase();
        sector_protected <= 2'h0;
        $display("test refused done");
    endtask : t_refused

    task automatic t_busy();
        other_cycle_busy <= 1'b1;
        frame(32'h0000_0033, 8);
        tick(flash_pkg::power_down_entry_cycles);
        check("entry_busy", low_power_active, 1'b0);
        check("standby_other", standby_active, 1'b0);
        other_cycle_busy <= 1'b0;
        tick(2);
        $display("test busy done");
    endtask : t_busy

    task automatic t_power_down();
        frame(32'h0000_3333, 16);
        tick(flash_pkg::power_down_entry_cycles);
        check("entry_long", low_power_active, 1'b0);
        frame(32'h0000_0033, 8);
        check("entry_delay", low_power_active, 1'b0);
        tick(flash_pkg::power_down_entry_cycles);
        check("entry", low_power_active, 1'b1);
        check("standby_pd", standby_active, 1'b0);
        frame(32'h0000_0011, 8);
        check("latch_pd", write_enable_latch, 1'b0);
        frame(32'h0000_4444, 16);
        tick(20);
        check("release_long", low_power_active, 1'b1);
        frame(32'h0000_0044, 8);
        check("release", low_power_active, 1'b0);
        check("standby_wait", standby_active, 1'b0);
        tick(flash_pkg::release_cycles);
        check("standby_back", standby_active, 1'b1);
        frame(32'h0000_0011, 8);
        check("latch_after", write_enable_latch, 1'b1);
        $display("test power_down done");
    endtask : t_power_down

    task automatic t_supply_loss();
        frame(32'h0000_0033, 8);
        tick(flash_pkg::power_down_entry_cycles);
        supply_ok <= 1'b0;
        tick(6);
        check("low_power_lost", low_power_active, 1'b0);
        check("latch_lost", write_enable_latch, 1'b0);
        i_host.idle_clocks(4);
        @(posedge core_clk);
        supply_ok <= 1'b1;
        tick(6);
        check("standby_up", standby_active, 1'b1);
        check("ready_again", write_ready, 1'b0);
        $display("test supply_loss done");
    endtask : t_supply_loss

    // =========================================================
    // hang guard and main sequence
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        tick(5);
        reset <= 1'b0;
        i_host.idle_clocks(4);
        @(posedge core_clk);
        supply_ok <= 1'b1;
        // let the link leave reset, then give the supply its settling time
        i_host.idle_clocks(4);
        tick(flash_pkg::supply_to_select_delay_us * 1000 / flash_pkg::core_clk_period_ns);
        tick(6);
        t_power_up();
        t_erase();
        t_refused();
        t_busy();
        t_power_down();
        t_supply_loss();
        test_done();
    end
endmodule : serial_flash_erase_power_control_test
`default_nettype wire
